// file: rtl/srnc_pkg.sv
/*
  Shared constants of the setpoint relay and node configuration block:
  register offsets, reset values, panel screens, keys and states.
  Assumes byte addresses on an APB bus with 32-bit data.
*/
package srnc_pkg;
  localparam int PRES_W = 16;
  localparam logic [7:0] A_R1ON = 8'h00;
  localparam logic [7:0] A_R1OFF = 8'h04;
  localparam logic [7:0] A_R2ON = 8'h08;
  localparam logic [7:0] A_R2OFF = 8'h0C;
  localparam logic [7:0] A_NODE = 8'h10;
  localparam logic [7:0] A_SER = 8'h14;
  localparam logic [7:0] A_UNIT = 8'h18;
  localparam logic [7:0] A_LMIN = 8'h1C;
  localparam logic [7:0] A_LMAX = 8'h20;
  localparam logic [7:0] A_ZERO = 8'h24;
  localparam logic [7:0] A_SPAN = 8'h28;
  localparam logic [7:0] A_STAT = 8'h2C;
  localparam logic [7:0] A_PRES = 8'h30;
  // Pressure counts are mTorr
  localparam logic [15:0] ON_RST = 16'h0064;
  localparam logic [15:0] OFF_RST = 16'h00C8;
  localparam logic [15:0] LMIN_RST = 16'h0001;
  localparam logic [15:0] LMAX_RST = 16'h03E8;
  localparam logic [15:0] ZERO_RST = 16'h0000;
  localparam logic [15:0] SPAN_RST = 16'h0000;
  localparam logic [3:0] NLO_RST = 4'h1;
  localparam logic [3:0] NHI_RST = 4'h0;
  localparam logic [3:0] NIB_MAX = 4'hF;
  // Rate codes 0..7: 1200,2400,4800,9600,19200,38400,57600,115200
  localparam logic [2:0] BAUD_RST = 3'h4;
  localparam logic [2:0] BAUD_MAX = 3'h7;
  localparam logic [1:0] PAR_RST = 2'h0;
  localparam logic [1:0] UNIT_RST = 2'h1;
  localparam logic [3:0] P_ZERO = 4'h0;
  localparam logic [3:0] P_SPAN = 4'h1;
  localparam logic [3:0] P_R1ON = 4'h2;
  localparam logic [3:0] P_R1OFF = 4'h3;
  localparam logic [3:0] P_R2ON = 4'h4;
  localparam logic [3:0] P_R2OFF = 4'h5;
  localparam logic [3:0] P_NLO = 4'h6;
  localparam logic [3:0] P_NHI = 4'h7;
  localparam logic [3:0] P_BAUD = 4'h8;
  localparam int K_MORE = 0;
  localparam int K_SAVE = 1;
  localparam int K_UP = 2;
  localparam int K_DOWN = 3;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_MENU = 2'b10
  } srnc_state_t;
endpackage : srnc_pkg

// file: rtl/srnc_relay.sv
/*
  One hysteretic setpoint relay with its two thresholds.
  Assumes pressure is sampled on pclk and writes arrive as pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module srnc_relay import srnc_pkg::*; #(
  parameter int PW = PRES_W
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic [PW-1:0] pressure, // measured pressure
  input wire logic inhibit_n, // low holds relay off
  input wire logic dflt, // load factory thresholds
  input wire logic wr_on, // write energize threshold
  input wire logic wr_off, // write release threshold
  input wire logic [PW-1:0] wdata, // threshold value
  output logic [PW-1:0] on_thr, // energize threshold
  output logic [PW-1:0] off_thr, // release threshold
  output logic energized // relay drive
);
  logic [PW-1:0] on_thr_reg;
  logic [PW-1:0] off_thr_reg;
  logic energized_reg;
  wire logic on_ok = wdata < off_thr_reg;
  wire logic off_ok = wdata > on_thr_reg;
  wire logic below = pressure < on_thr_reg;
  wire logic above = pressure > off_thr_reg;

  assign on_thr = on_thr_reg;
  assign off_thr = off_thr_reg;
  assign energized = energized_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_thr_reg <= PW'(ON_RST);
      off_thr_reg <= PW'(OFF_RST);
    end else if (dflt) begin
      on_thr_reg <= PW'(ON_RST);
      off_thr_reg <= PW'(OFF_RST);
    end else begin
      if (wr_on && on_ok) begin
        on_thr_reg <= wdata;
      end
      if (wr_off && off_ok) begin
        off_thr_reg <= wdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      energized_reg <= 1'b0;
    end else if (!inhibit_n) begin
      energized_reg <= 1'b0;
    end else if (below) begin
      energized_reg <= 1'b1;
    end else if (above) begin
      energized_reg <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  energize_low_a: assert property (inhibit_n && below |=> energized)
    else $error("relay not energized below threshold");
  release_high_a: assert property (inhibit_n && above |=> !energized)
    else $error("relay not released above threshold");
  band_hold_a: assert property (inhibit_n && !below && !above
    |=> energized == $past(energized))
    else $error("relay changed inside band");
  inhibit_off_a: assert property (!inhibit_n |=> !energized)
    else $error("relay energized while inhibited");
  order_kept_a: assert property (on_thr < off_thr)
    else $error("energize threshold not below release");
  dflt_load_a: assert property (dflt |=> on_thr == PW'(ON_RST)
    && off_thr == PW'(OFF_RST))
    else $error("factory thresholds not loaded");
endmodule : srnc_relay
`default_nettype wire

// file: rtl/srnc_top.sv
/*
  Setpoint relay and node configuration: APB register file, front
  panel programming flow, two setpoint relays, node address and
  serial line settings. Assumes keys are one-cycle pulses synchronous
  to pclk and pressure is a settled sample in mTorr counts.
*/
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Relay energizes when pressure drops below its energize threshold.
// - Relay releases when pressure rises above its release threshold.
// - Factory thresholds: energize at 100 mTorr, release at 200 mTorr.
// - Energize threshold may never be raised to or past release.
// - Release threshold may never be lowered to or below energize.
// - Grounded inhibit input holds both relays released.
// - Node address low nibble from low setting, default 1.
// - Node address high nibble from high setting, default 0.
// - One node address serves both serial ports; host must send it.
// - Unit change restores thresholds and linear output settings.
// - One line rate for both ports, default 19200, panel or serial.
// - Parity changes only over the serial path, never from panel.
// - Any key while idle enters programming and shows the menu.
// - Advance key steps screens; store key commits and exits.
// - Zero capture key records present pressure as zero reference.
// - Span screen keys adjust value; store commits span reference.
module srnc_top import srnc_pkg::*; #(
  parameter int PW = PRES_W
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic [PW-1:0] pressure, // measured pressure
  input wire logic relay_inhibit_n, // low: relays held off
  input wire logic [3:0] panel_key, // key pulses
  output logic [1:0] relay_on, // relay drives
  output logic [7:0] node_addr, // serial node address
  output logic [2:0] baud_sel, // line rate code
  output logic [1:0] parity_sel, // parity code
  output logic [1:0] unit_sel, // pressure unit
  output logic [PW-1:0] lin_min, // linear out low pressure
  output logic [PW-1:0] lin_max, // linear out high pressure
  output logic [PW-1:0] zero_ref, // vacuum zero reference
  output logic [PW-1:0] span_ref, // atmospheric span ref
  output logic panel_active, // programming mode
  output logic [3:0] menu_screen, // screen shown
  output logic [PW-1:0] edit_value // value shown
);
  srnc_state_t state_reg;
  srnc_state_t state_next;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] prdata_reg;
  logic [3:0] nlo_reg;
  logic [3:0] nhi_reg;
  logic [2:0] baud_reg;
  logic [1:0] parity_reg;
  logic [1:0] unit_reg;
  logic [PW-1:0] lmin_reg;
  logic [PW-1:0] lmax_reg;
  logic [PW-1:0] zero_reg;
  logic [PW-1:0] span_reg;
  logic [3:0] screen_reg;
  logic [3:0] screen_next;
  logic [PW-1:0] edit_reg;
  logic [PW-1:0] edit_next;
  logic [PW-1:0] on_thr [2];
  logic [PW-1:0] off_thr [2];
  logic [1:0] energized;
  logic [31:0] rd_mux;
  logic rd_hit;
  logic [PW-1:0] cur_val;
  logic [PW-1:0] edit_max;

  // Slave answers on the second access cycle
  wire logic acc = psel && penable;
  wire logic apb_wr = acc && pwrite && pready_reg;
  wire logic wr_node = apb_wr && paddr == A_NODE;
  wire logic wr_ser = apb_wr && paddr == A_SER;
  wire logic wr_unit = apb_wr && paddr == A_UNIT;
  wire logic wr_lmin = apb_wr && paddr == A_LMIN;
  wire logic wr_lmax = apb_wr && paddr == A_LMAX;
  wire logic unit_chg = wr_unit && pwdata[1:0] != unit_reg;
  wire logic idle = state_reg == ST_IDLE;
  wire logic menu = state_reg == ST_MENU;
  wire logic any_key = |panel_key;
  wire logic k_more = panel_key[K_MORE];
  wire logic k_up = panel_key[K_UP];
  wire logic k_down = panel_key[K_DOWN];
  // A store colliding with a bus write is dropped; operator repeats it
  wire logic pnl_save = menu && panel_key[K_SAVE] && !apb_wr;
  wire logic [3:0] scr_inc = (screen_reg == P_BAUD) ? P_ZERO
    : screen_reg + 4'h1;
  wire logic zero_cap = menu && !pnl_save && !k_more && k_up
    && screen_reg == P_ZERO;

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;
  assign relay_on = energized;
  assign node_addr = {nhi_reg, nlo_reg};
  assign baud_sel = baud_reg;
  assign parity_sel = parity_reg;
  assign unit_sel = unit_reg;
  assign lin_min = lmin_reg;
  assign lin_max = lmax_reg;
  assign zero_ref = zero_reg;
  assign span_ref = span_reg;
  assign panel_active = state_reg[1];
  assign menu_screen = screen_reg;
  assign edit_value = edit_reg;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_relay
      wire logic [7:0] a_on = g ? A_R2ON : A_R1ON;
      wire logic [7:0] a_off = g ? A_R2OFF : A_R1OFF;
      wire logic [3:0] p_on = g ? P_R2ON : P_R1ON;
      wire logic [3:0] p_off = g ? P_R2OFF : P_R1OFF;
      wire logic bus_on = apb_wr && paddr == a_on;
      wire logic bus_off = apb_wr && paddr == a_off;
      wire logic pnl_on = pnl_save && screen_reg == p_on;
      wire logic pnl_off = pnl_save && screen_reg == p_off;
      wire logic [PW-1:0] wval = apb_wr ? pwdata[PW-1:0] : edit_reg;
      srnc_relay #(.PW(PW)) u_relay (
        .pclk(pclk),
        .presetn(presetn),
        .pressure(pressure),
        .inhibit_n(relay_inhibit_n),
        .dflt(unit_chg),
        .wr_on(bus_on || pnl_on),
        .wr_off(bus_off || pnl_off),
        .wdata(wval),
        .on_thr(on_thr[g]),
        .off_thr(off_thr[g]),
        .energized(energized[g])
      );
    end
  endgenerate

  // Setting of the next screen, or present pressure for span, loaded into the edit value
  always_comb begin
    cur_val = '0;
    edit_max = '1;
    unique case (scr_inc)
      P_ZERO: cur_val = zero_reg;
      P_SPAN: cur_val = pressure;
      P_R1ON: cur_val = on_thr[0];
      P_R1OFF: cur_val = off_thr[0];
      P_R2ON: cur_val = on_thr[1];
      P_R2OFF: cur_val = off_thr[1];
      P_NLO: cur_val = PW'(nlo_reg);
      P_NHI: cur_val = PW'(nhi_reg);
      P_BAUD: cur_val = PW'(baud_reg);
      default: cur_val = '0;
    endcase
    if (screen_reg == P_NLO || screen_reg == P_NHI) begin
      edit_max = PW'(NIB_MAX);
    end else if (screen_reg == P_BAUD) begin
      edit_max = PW'(BAUD_MAX);
    end
  end

  // Panel flow
  always_comb begin
    state_next = state_reg;
    screen_next = screen_reg;
    edit_next = edit_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (any_key) begin
          state_next = ST_MENU;
          screen_next = P_ZERO;
          edit_next = zero_reg;
        end
      end
      ST_MENU: begin
        if (pnl_save) begin
          state_next = ST_IDLE;
        end else if (k_more) begin
          screen_next = scr_inc;
          edit_next = cur_val;
        end else if (zero_cap) begin
          edit_next = pressure;
        end else if (k_up && edit_reg < edit_max) begin
          edit_next = edit_reg + PW'(1);
        end else if (k_down && edit_reg != '0) begin
          edit_next = edit_reg - PW'(1);
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      screen_reg <= P_ZERO;
      edit_reg <= '0;
    end else begin
      state_reg <= state_next;
      screen_reg <= screen_next;
      edit_reg <= edit_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_reg <= PW'(ZERO_RST);
      span_reg <= PW'(SPAN_RST);
    end else begin
      if (zero_cap) begin
        zero_reg <= pressure;
      end
      if (pnl_save && screen_reg == P_SPAN) begin
        span_reg <= edit_reg;
      end
    end
  end

  // Node address and line settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nlo_reg <= NLO_RST;
      nhi_reg <= NHI_RST;
      baud_reg <= BAUD_RST;
      parity_reg <= PAR_RST;
    end else if (wr_node) begin
      nlo_reg <= pwdata[3:0];
      nhi_reg <= pwdata[7:4];
    end else if (wr_ser) begin
      baud_reg <= pwdata[2:0];
      parity_reg <= pwdata[5:4];
    end else if (pnl_save) begin
      if (screen_reg == P_NLO) nlo_reg <= edit_reg[3:0];
      if (screen_reg == P_NHI) nhi_reg <= edit_reg[3:0];
      if (screen_reg == P_BAUD) baud_reg <= edit_reg[2:0];
    end
  end

  // Changing units drops linear output settings back to defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unit_reg <= UNIT_RST;
      lmin_reg <= PW'(LMIN_RST);
      lmax_reg <= PW'(LMAX_RST);
    end else if (unit_chg) begin
      unit_reg <= pwdata[1:0];
      lmin_reg <= PW'(LMIN_RST);
      lmax_reg <= PW'(LMAX_RST);
    end else begin
      if (wr_lmin) lmin_reg <= pwdata[PW-1:0];
      if (wr_lmax) lmax_reg <= pwdata[PW-1:0];
    end
  end

  // Read mux
  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (paddr)
      A_R1ON: rd_mux = 32'(on_thr[0]);
      A_R1OFF: rd_mux = 32'(off_thr[0]);
      A_R2ON: rd_mux = 32'(on_thr[1]);
      A_R2OFF: rd_mux = 32'(off_thr[1]);
      A_NODE: rd_mux = 32'({nhi_reg, nlo_reg});
      A_SER: rd_mux = 32'({parity_reg, 1'b0, baud_reg});
      A_UNIT: rd_mux = 32'(unit_reg);
      A_LMIN: rd_mux = 32'(lmin_reg);
      A_LMAX: rd_mux = 32'(lmax_reg);
      A_ZERO: rd_mux = 32'(zero_reg);
      A_SPAN: rd_mux = 32'(span_reg);
      A_STAT: rd_mux = 32'({screen_reg, state_reg,
        relay_inhibit_n, energized});
      A_PRES: rd_mux = 32'(pressure);
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= acc && !pready_reg;
      pslverr_reg <= acc && !pready_reg && !rd_hit;
      if (acc && !pready_reg && !pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  node_write_a: assert property (wr_node
    |=> node_addr == $past(pwdata[7:0]))
    else $error("node address not taken from settings");
  node_dflt_a: assert property ($rose(presetn) |-> node_addr == 8'h01
    && baud_sel == BAUD_RST)
    else $error("node or rate default wrong");
  parity_keep_a: assert property (!wr_ser |=> $stable(parity_sel))
    else $error("parity changed without serial write");
  unit_reset_a: assert property (unit_chg |=> lin_min == PW'(LMIN_RST)
    && lin_max == PW'(LMAX_RST) && on_thr[0] == PW'(ON_RST))
    else $error("unit change kept old settings");
  key_enter_a: assert property (idle && any_key
    |=> panel_active && menu_screen == P_ZERO)
    else $error("key did not enter programming");
  store_exit_a: assert property (pnl_save |=> !panel_active)
    else $error("store did not return to main screen");
  more_step_a: assert property (menu && !pnl_save && k_more
    |=> menu_screen == $past(scr_inc))
    else $error("advance did not step screen");
  zero_take_a: assert property (zero_cap
    |=> zero_ref == $past(pressure))
    else $error("zero not captured");
  span_take_a: assert property (pnl_save && screen_reg == P_SPAN
    |=> span_ref == $past(edit_reg))
    else $error("span not committed");
  // Bus write wins; the dropped store leaves the operator in the menu
  save_block_a: assert property (menu && panel_key[K_SAVE]
    && apb_wr |=> panel_active)
    else $error("store taken during bus write");
  panel_r1on_a: assert property (pnl_save && screen_reg == P_R1ON
    && edit_reg < off_thr[0] |=> on_thr[0] == $past(edit_reg))
    else $error("panel threshold not committed");
  panel_nlo_a: assert property (pnl_save && screen_reg == P_NLO
    |=> node_addr[3:0] == $past(edit_reg[3:0]))
    else $error("panel low nibble not committed");
  panel_rate_a: assert property (pnl_save && screen_reg == P_BAUD
    |=> baud_sel == $past(edit_reg[2:0]))
    else $error("panel rate not committed");
  rate_cap_a: assert property (menu && screen_reg == P_BAUD
    |-> edit_reg <= PW'(BAUD_MAX))
    else $error("rate edit beyond last code");
  down_floor_a: assert property (menu && k_down && !k_up
    && !k_more && !pnl_save && edit_reg == '0 |=> edit_value == '0)
    else $error("edit value wrapped below zero");
  relay_pick_c: cover property (!relay_on[0] ##1 relay_on[0]);
  zero_cap_c: cover property (zero_cap);
  span_save_c: cover property (pnl_save && screen_reg == P_SPAN);
  unit_chg_c: cover property (unit_chg);
  thr_save_c: cover property (pnl_save && screen_reg == P_R1ON);
endmodule : srnc_top
`default_nettype wire

// file: tb/srnc_far_side.sv
/*
  Far-side model: serial host as APB master, panel operator, gauge
  sensor and the relay-inhibit wire. Assumes one rising-edge clock.
*/
`timescale 1ns/1ps
`default_nettype none
module srnc_far_side (
  input wire logic pclk, // system clock
  output logic psel, // APB select
  output logic penable, // APB enable
  output logic pwrite, // APB direction
  output logic [7:0] paddr, // APB address
  output logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  output logic [15:0] pressure, // sensor reading
  output logic relay_inhibit_n, // inhibit wire, pulled high
  output logic [3:0] panel_key // key pulses
);
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'hFF;
    pwdata = 32'hFFFFFFFF;
    pressure = 16'h03E8;
    relay_inhibit_n = 1'h1;
    panel_key = 4'h0;
  end

  // Released lines carry inverted data so stale values never pass
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e,
      output logic to);
    int i;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    to = 1'h1;
    for (i = 0; i < 16 && to; i++) begin
      @(posedge pclk);
      if (pready === 1'h1) begin
        r = prdata;
        e = pslverr;
        to = 1'h0;
      end
    end
    psel <= 1'h0;
    penable <= 1'h0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : apb

  // One-cycle key pulse, then one edge for the response to land
  task automatic press(input logic [3:0] k);
    @(posedge pclk);
    panel_key <= k;
    @(posedge pclk);
    panel_key <= 4'h0;
    @(posedge pclk);
  endtask : press

  task automatic set_in(input logic [15:0] v, input logic inh_n);
    @(posedge pclk);
    pressure <= v;
    relay_inhibit_n <= inh_n;
    repeat (2) @(posedge pclk);
  endtask : set_in
endmodule : srnc_far_side
`default_nettype wire

// file: tb/srnc_tb_top.sv
/*
  Self-checking bench for the relay and node configuration block.
  Assumes the far-side model drives every non-clock input except presetn, which the bench drives.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin \
  tests_run++; \
  if ((a) !== (e)) begin \
    n_fail++; \
    $display("BAD %s expected %0h seen %0h", nm, e, a); \
  end \
end
module srnc_tb_top import srnc_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic relay_inhibit_n, panel_active;
  logic [7:0] paddr, node_addr;
  logic [31:0] pwdata, prdata;
  logic [15:0] pressure, lin_min, lin_max, zero_ref, span_ref, edit_value;
  logic [3:0] panel_key, menu_screen;
  logic [1:0] relay_on, parity_sel, unit_sel;
  logic [2:0] baud_sel;
  int n_fail = 0;
  int tests_run = 0;

  srnc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pressure(pressure), .relay_inhibit_n(relay_inhibit_n),
    .panel_key(panel_key), .relay_on(relay_on), .node_addr(node_addr),
    .baud_sel(baud_sel), .parity_sel(parity_sel), .unit_sel(unit_sel),
    .lin_min(lin_min), .lin_max(lin_max), .zero_ref(zero_ref),
    .span_ref(span_ref), .panel_active(panel_active),
    .menu_screen(menu_screen), .edit_value(edit_value));

  srnc_far_side p (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pressure(pressure),
    .relay_inhibit_n(relay_inhibit_n), .panel_key(panel_key));

  initial begin
    pclk = 1'h0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic bus_hung();
    n_fail++;
    $display("BAD pready expected 1 seen 0");
    print_verdict();
  endtask : bus_hung

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e, to;
    p.apb(1'h1, a, d, r, e, to);
    if (to) bus_hung();
  endtask : wr

  task automatic chkrd(input logic [7:0] a, input logic [31:0] x,
      input logic xe);
    logic [31:0] r;
    logic e, to;
    p.apb(1'h0, a, 32'h0, r, e, to);
    if (to) bus_hung();
    `CHK("prdata", x, r)
    `CHK("pslverr", xe, e)
  endtask : chkrd

  task automatic t_reset();
    `CHK("node_addr", 8'h01, node_addr)
    `CHK("baud_sel", 3'h4, baud_sel)
    chkrd(A_R1ON, 32'h64, 1'h0);
    chkrd(A_R1OFF, 32'hC8, 1'h0);
    chkrd(A_R2ON, 32'h64, 1'h0);
    chkrd(A_R2OFF, 32'hC8, 1'h0);
    chkrd(A_NODE, 32'h01, 1'h0);
    chkrd(8'h40, 32'h0, 1'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_hyst();
    p.set_in(16'h0032, 1'h1);
    `CHK("relay_on", 2'h3, relay_on)
    p.set_in(16'h0096, 1'h1);
    `CHK("relay_on", 2'h3, relay_on)
    p.set_in(16'h00C8, 1'h1);
    `CHK("relay_on", 2'h3, relay_on)
    p.set_in(16'h00C9, 1'h1);
    `CHK("relay_on", 2'h0, relay_on)
    p.set_in(16'h0064, 1'h1);
    `CHK("relay_on", 2'h0, relay_on)
    p.set_in(16'h0063, 1'h1);
    `CHK("relay_on", 2'h3, relay_on)
    p.set_in(16'h0032, 1'h0);
    `CHK("relay_on", 2'h0, relay_on)
    p.set_in(16'h0032, 1'h1);
    `CHK("relay_on", 2'h3, relay_on)
    $display("test hysteresis done");
  endtask : t_hyst

  task automatic t_order();
    wr(A_R1ON, 32'hC8);
    chkrd(A_R1ON, 32'h64, 1'h0);
    wr(A_R1ON, 32'hC7);
    chkrd(A_R1ON, 32'hC7, 1'h0);
    wr(A_R1OFF, 32'hC7);
    chkrd(A_R1OFF, 32'hC8, 1'h0);
    wr(A_R2ON, 32'h100);
    chkrd(A_R2ON, 32'h64, 1'h0);
    wr(A_R2OFF, 32'h12C);
    wr(A_R2ON, 32'h100);
    chkrd(A_R2ON, 32'h100, 1'h0);
    wr(A_R2OFF, 32'h101);
    chkrd(A_R2OFF, 32'h101, 1'h0);
    // Relays must act on their own thresholds only
    p.set_in(16'h00FA, 1'h1);
    `CHK("relay_on", 2'h2, relay_on)
    $display("test threshold order done");
  endtask : t_order

  task automatic t_unit();
    wr(A_LMIN, 32'h5);
    chkrd(A_LMIN, 32'h5, 1'h0);
    `CHK("lin_min", 16'h5, lin_min)
    wr(A_UNIT, 32'h2);
    chkrd(A_UNIT, 32'h2, 1'h0);
    `CHK("unit_sel", 2'h2, unit_sel)
    chkrd(A_R1ON, 32'h64, 1'h0);
    chkrd(A_R1OFF, 32'hC8, 1'h0);
    chkrd(A_R2ON, 32'h64, 1'h0);
    chkrd(A_R2OFF, 32'hC8, 1'h0);
    chkrd(A_LMIN, 32'h1, 1'h0);
    chkrd(A_LMAX, 32'h3E8, 1'h0);
    `CHK("lin_min", 16'h1, lin_min)
    `CHK("lin_max", 16'h3E8, lin_max)
    $display("test unit change done");
  endtask : t_unit

  task automatic t_node();
    logic [7:0] v [3] = '{8'h0F, 8'h50, 8'hF0};
    foreach (v[i]) begin
      wr(A_NODE, {24'h0, v[i]});
      chkrd(A_NODE, {24'h0, v[i]}, 1'h0);
      `CHK("node_addr", v[i], node_addr)
    end
    $display("test node address done");
  endtask : t_node

  task automatic t_panel();
    p.set_in(16'h0033, 1'h1);
    p.press(4'h8);
    `CHK("panel_active", 1'h1, panel_active)
    `CHK("menu_screen", P_ZERO, menu_screen)
    `CHK("edit_value", 16'h0, edit_value)
    p.press(4'h4);
    `CHK("zero_ref", 16'h0033, zero_ref)
    p.press(4'h1);
    `CHK("menu_screen", P_SPAN, menu_screen)
    `CHK("edit_value", 16'h0033, edit_value)
    p.press(4'h4);
    p.press(4'h4);
    p.press(4'h8);
    `CHK("edit_value", 16'h0034, edit_value)
    p.press(4'h2);
    `CHK("span_ref", 16'h0034, span_ref)
    `CHK("panel_active", 1'h0, panel_active)
    wr(A_SPAN, 32'h0);
    chkrd(A_SPAN, 32'h34, 1'h0);
    $display("test panel zero and span done");
  endtask : t_panel

  task automatic t_rate();
    int i;
    wr(A_SER, 32'h25);
    chkrd(A_SER, 32'h25, 1'h0);
    `CHK("parity_sel", 2'h2, parity_sel)
    for (i = 0; i < 9; i++) p.press(4'h1);
    `CHK("menu_screen", P_BAUD, menu_screen)
    `CHK("edit_value", 16'h5, edit_value)
    for (i = 0; i < 3; i++) p.press(4'h4);
    `CHK("edit_value", 16'h7, edit_value)
    p.press(4'h2);
    `CHK("baud_sel", 3'h7, baud_sel)
    `CHK("parity_sel", 2'h2, parity_sel)
    $display("test line rate done");
  endtask : t_rate

  task automatic t_pnlset();
    int i;
    for (i = 0; i < 3; i++) p.press(4'h1);
    `CHK("menu_screen", P_R1ON, menu_screen)
    `CHK("edit_value", 16'h64, edit_value)
    p.press(4'h4);
    p.press(4'h2);
    chkrd(A_R1ON, 32'h65, 1'h0);
    for (i = 0; i < 7; i++) p.press(4'h1);
    `CHK("menu_screen", P_NLO, menu_screen)
    // Down at zero must hold, not wrap
    p.press(4'h8);
    `CHK("edit_value", 16'h0, edit_value)
    p.press(4'h4);
    p.press(4'h2);
    `CHK("node_addr", 8'hF1, node_addr)
    $display("test panel settings done");
  endtask : t_pnlset

  initial begin
    presetn = 1'h0;
    repeat (12) @(posedge pclk);
    `CHK("relay_on", 2'h0, relay_on)
    presetn <= 1'h1;
    t_reset();
    t_hyst();
    t_order();
    t_unit();
    t_node();
    t_panel();
    t_rate();
    t_pnlset();
    print_verdict();
  end
endmodule : srnc_tb_top
`undef CHK
`default_nettype wire
